// >>> design/prs_top.sv
// Request sideband upper block: abort, hint, progress number, parity
// Function
// - Raised abort flag makes the device nullify the matching packet on the link.
// - Abort may come on any beat; packet stays errored to its end.
// - Abort raised only with valid, sampled only with ready; user holds it.
// - As endpoint, an aborted packet is also reported as an error message.
// - Hint-present bit sampled on first handshake beat; zero when hints unused.
// - Two-bit hint type sampled on first beat; ignored without hint present.
// - Indirect bit set selects table entry by low steering bits, else direct.
// - Eight-bit steering value sampled on first beat; ignored without hint.
// - Progress number captured on first beat, shown once the packet leaves.
// - Only parity bits of the configured payload width are checked.
// - Parity mismatch nullifies the packet and reports an internal error.
// - Progress valid pulses exactly one cycle with each new progress number.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
module prs_top
   import prs_pkg::*;
#(
   parameter int DATA_W    = 256,
   parameter int STT_DEPTH = 4
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              resetn_i,
   // Register bus
   input  wire prs_axil_req_t     axil_req_i,
   output prs_axil_rsp_t          axil_rsp_o,
   // Request stream from user
   input  wire logic [DATA_W-1:0] request_stream_payload_i,
   input  wire prs_sideband_t     request_sideband_i,
   input  wire logic              request_stream_last_i,
   input  wire logic              request_stream_valid_i,
   output logic                   request_stream_ready_o,
   // Link side
   output logic [DATA_W-1:0]      link_data_o,
   output logic                   link_last_o,
   output logic                   link_nullify_o,
   output logic                   link_valid_o,
   input  wire logic              link_ready_i,
   output prs_hint_t              link_hint_o,
   // Progress and error reports
   output logic [3:0]             progress_number_out_o,
   output logic                   progress_number_out_valid_o,
   output logic                   aer_abort_report_o,
   output logic                   internal_error_report_o,
   output logic                   irq_o
);

   localparam int IDX_W = (STT_DEPTH > 1) ? $clog2(STT_DEPTH) : 1;
   // Bus state
   logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]        bresp_ff, rresp_ff;
   logic [31:0]       rdata_ff;
   logic              aw_got_ff, w_got_ff;
   logic [7:0]        awaddr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              aw_take, w_take, wr_do, ar_take, nxt_aw_got, nxt_w_got, nxt_rvalid;

   // Registers
   logic [31:0]       ctrl_ff, mask_ff;
   logic [EV_W-1:0]   status_ff, nxt_status, ev_set, ev_clr;
   logic [7:0]        stt_ff [STT_DEPTH];

   // Stream state
   prs_pkt_st_t       st_ff;
   logic              ready_ff, out_valid_ff, nxt_out_valid, take, drain, first;
   logic              abort_ff, perr_ff, par_bad, perr_now, beat_bad;
   logic [DATA_W-1:0] data_ff;
   logic              last_ff, nullify_ff, prog_vld_ff, aer_ff, ierr_ff, irq_ff;
   prs_hint_t         hint_ff;
   logic [3:0]        seq_ff, prog_ff;
   logic [7:0]        stt_rd, tag_sel;

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   // Register decode
   function automatic logic mapped(input logic [7:0] a);
      logic ok;
      ok = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_MASK) || (a == OFF_HINT);
      for (int i = 0; i < STT_DEPTH; i++) begin
         ok = ok || (a == OFF_STT_BASE + 8'(4 * i));
      end
      return ok;
   endfunction : mapped

   // Write channel handshakes, address and data in either order
   assign aw_take    = axil_req_i.awvalid & awready_ff;
   assign w_take     = axil_req_i.wvalid & wready_ff;
   assign wr_do      = aw_got_ff & w_got_ff & ~bvalid_ff;
   assign nxt_aw_got = aw_take | (aw_got_ff & ~wr_do);
   assign nxt_w_got  = w_take | (w_got_ff & ~wr_do);
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
      end else begin
         aw_got_ff  <= nxt_aw_got;
         w_got_ff   <= nxt_w_got;
         awready_ff <= ~nxt_aw_got;
         wready_ff  <= ~nxt_w_got;
         if (aw_take) begin
            awaddr_ff <= axil_req_i.awaddr;
         end
         if (w_take) begin
            wdata_ff <= axil_req_i.wdata;
            wstrb_ff <= axil_req_i.wstrb;
         end
      end
   end

   // Write response
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req_i.bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Control, mask and steering table
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_ff <= CTRL_RST;
         mask_ff <= MASK_RST;
      end else if (wr_do) begin
         if (awaddr_ff == OFF_CTRL) begin
            ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
         end
         if (awaddr_ff == OFF_MASK) begin
            mask_ff <= merge(mask_ff, wdata_ff, wstrb_ff);
         end
      end
   end

   for (genvar i = 0; i < STT_DEPTH; i++) begin : g_stt
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            stt_ff[i] <= STT_RST;
         end else if (wr_do && awaddr_ff == OFF_STT_BASE + 8'(4 * i) && wstrb_ff[0]) begin
            stt_ff[i] <= wdata_ff[7:0];
         end
      end
   end

   // Sticky events, write one to clear, set wins
   assign ev_clr = (wr_do && awaddr_ff == OFF_STATUS && wstrb_ff[0]) ? wdata_ff[EV_W-1:0] : '0;
   assign ev_set = {prog_vld_ff, ierr_ff, aer_ff};
   assign nxt_status = (status_ff & ~ev_clr) | ev_set;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_ff <= '0;
         irq_ff    <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         irq_ff    <= |(nxt_status & mask_ff[EV_W-1:0]);
      end
   end

   // Read channel
   assign ar_take    = axil_req_i.arvalid & arready_ff;
   assign nxt_rvalid = ar_take | (rvalid_ff & ~axil_req_i.rready);
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= RESP_OKAY;
      end else begin
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= ~nxt_rvalid;
         if (ar_take) begin
            rresp_ff <= mapped(axil_req_i.araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= 32'h0000_0000;
            case (axil_req_i.araddr)
               OFF_CTRL:   rdata_ff <= ctrl_ff;
               OFF_STATUS: rdata_ff <= 32'(status_ff);
               OFF_MASK:   rdata_ff <= mask_ff;
               OFF_HINT: begin
                  rdata_ff[HINT_TAG_LSB +: 8] <= hint_ff.tag;
                  rdata_ff[HINT_PH_LSB +: 2]  <= hint_ff.ph;
                  rdata_ff[HINT_PRES]         <= hint_ff.present;
                  rdata_ff[HINT_SEQ_LSB +: 4] <= seq_ff;
               end
               default: begin
                  for (int i = 0; i < STT_DEPTH; i++) begin
                     if (axil_req_i.araddr == OFF_STT_BASE + 8'(4 * i)) begin
                        rdata_ff <= 32'(stt_ff[i]);
                     end
                  end
               end
            endcase
         end
      end
   end

   // Parity check on each accepted beat
   prs_parity_chk #(
      .DATA_W (DATA_W),
      .PAR_W  (32)
   ) u_par (
      .data_i     (request_stream_payload_i),
      .parity_i   (request_sideband_i.parity),
      .mismatch_o (par_bad)
   );

   // One-stage slice toward the link
   assign take          = request_stream_valid_i & ready_ff;
   assign drain         = out_valid_ff & link_ready_i;
   assign nxt_out_valid = take | (out_valid_ff & ~link_ready_i);
   assign first         = (st_ff == ST_FIRST);
   assign perr_now      = ctrl_ff[CTRL_PAR_EN] & par_bad;
   assign beat_bad      = request_sideband_i.abort | abort_ff | perr_now | perr_ff;
   assign stt_rd        = stt_ff[request_sideband_i.steering_value[IDX_W-1:0]];
   assign tag_sel       = request_sideband_i.tph_indirect ? stt_rd :
                          request_sideband_i.steering_value;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ready_ff     <= 1'b0;
         out_valid_ff <= 1'b0;
         data_ff      <= '0;
         last_ff      <= 1'b0;
         nullify_ff   <= 1'b0;
      end else begin
         ready_ff     <= ~nxt_out_valid;
         out_valid_ff <= nxt_out_valid;
         if (take) begin
            data_ff    <= request_stream_payload_i;
            last_ff    <= request_stream_last_i;
            nullify_ff <= beat_bad;
         end
      end
   end

   // Packet position and sticky errors
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_ff    <= ST_FIRST;
         abort_ff <= 1'b0;
         perr_ff  <= 1'b0;
      end else if (take) begin
         case (st_ff)
            ST_FIRST: st_ff <= request_stream_last_i ? ST_FIRST : ST_BODY;
            ST_BODY:  st_ff <= request_stream_last_i ? ST_FIRST : ST_BODY;
            default:  st_ff <= ST_FIRST;
         endcase
         abort_ff <= ~request_stream_last_i & (abort_ff | request_sideband_i.abort);
         perr_ff  <= ~request_stream_last_i & (perr_ff | perr_now);
      end
   end

   // Hint and progress number captured on the first beat
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hint_ff <= '0;
         seq_ff  <= 4'h0;
      end else if (take && first) begin
         hint_ff.present <= request_sideband_i.tph_present;
         hint_ff.ph      <= request_sideband_i.tph_present ?
                            request_sideband_i.tph_type : 2'h0;
         hint_ff.tag     <= request_sideband_i.tph_present ? tag_sel : 8'h00;
         seq_ff          <= request_sideband_i.seq;
      end
   end

   // Reports at packet end, progress once the last beat has left
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aer_ff      <= 1'b0;
         ierr_ff     <= 1'b0;
         prog_vld_ff <= 1'b0;
         prog_ff     <= 4'h0;
      end else begin
         aer_ff      <= take & request_stream_last_i & ctrl_ff[CTRL_ENDPOINT] &
                        (request_sideband_i.abort | abort_ff);
         ierr_ff     <= take & request_stream_last_i & (perr_now | perr_ff);
         prog_vld_ff <= drain & last_ff;
         if (drain && last_ff) begin
            prog_ff <= seq_ff;
         end
      end
   end

   // Outputs
   assign request_stream_ready_o      = ready_ff;
   assign link_data_o                 = data_ff;
   assign link_last_o                 = last_ff;
   assign link_nullify_o              = nullify_ff;
   assign link_valid_o                = out_valid_ff;
   assign link_hint_o                 = hint_ff;
   assign progress_number_out_o       = prog_ff;
   assign progress_number_out_valid_o = prog_vld_ff;
   assign aer_abort_report_o          = aer_ff;
   assign internal_error_report_o     = ierr_ff;
   assign irq_o                       = irq_ff;
   assign axil_rsp_o = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff,
                         bresp: bresp_ff, arready: arready_ff, rvalid: rvalid_ff,
                         rdata: rdata_ff, rresp: rresp_ff};

   // Checks
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   a_abort_nullify: assert property (
      take && request_sideband_i.abort |=> link_valid_o && link_nullify_o)
      else $error("aborted beat not nullified");
   a_abort_sticky: assert property (
      take && abort_ff |=> link_valid_o && link_nullify_o)
      else $error("abort not sticky to later beat");
   a_abort_sample: assert property (
      !take |=> $stable(abort_ff) && $stable(nullify_ff))
      else $error("abort sampled without handshake");
   a_aer_report: assert property (
      take && request_stream_last_i && ctrl_ff[CTRL_ENDPOINT] && request_sideband_i.abort
      |=> aer_abort_report_o ##1 status_ff[EV_ABORT])
      else $error("abort not reported");
   a_hint_present: assert property (
      take && first |=> link_hint_o.present == $past(request_sideband_i.tph_present))
      else $error("hint present not captured");
   a_hint_type: assert property (
      take && first && request_sideband_i.tph_present
      |=> link_hint_o.ph == $past(request_sideband_i.tph_type))
      else $error("hint type not captured");
   a_tag_select: assert property (
      take && first && request_sideband_i.tph_present && !request_sideband_i.tph_indirect
      |=> link_hint_o.tag == $past(request_sideband_i.steering_value))
      else $error("direct steering value wrong");
   a_hint_hold: assert property (
      st_ff == ST_BODY && !(take && first) |=> $stable(link_hint_o))
      else $error("hint changed mid packet");
   a_progress_num: assert property (
      drain && last_ff |=> progress_number_out_valid_o && progress_number_out_o == $past(seq_ff))
      else $error("progress number wrong");
   a_parity_err: assert property (
      take && request_stream_last_i && ctrl_ff[CTRL_PAR_EN] && par_bad
      |=> link_nullify_o && internal_error_report_o)
      else $error("parity error not handled");
   a_prog_pulse: assert property (
      progress_number_out_valid_o |=> !progress_number_out_valid_o)
      else $error("progress valid longer than one cycle");

endmodule : prs_top

// >>> common/prs_pkg.sv
// Shared constants and types for the request sideband upper block
package prs_pkg;

   // Register map, byte addresses
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_STATUS    = 8'h04;
   localparam logic [7:0]  OFF_MASK      = 8'h08;
   localparam logic [7:0]  OFF_HINT      = 8'h0C;
   localparam logic [7:0]  OFF_STT_BASE  = 8'h20;

   // Control fields and reset values
   localparam int          CTRL_PAR_EN   = 0;
   localparam int          CTRL_ENDPOINT = 1;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0003;
   localparam logic [31:0] MASK_RST      = 32'h0000_0000;
   localparam logic [7:0]  STT_RST       = 8'h00;

   // Event bits in status and mask
   localparam int          EV_ABORT      = 0;
   localparam int          EV_PARITY     = 1;
   localparam int          EV_PROGRESS   = 2;
   localparam int          EV_W          = 3;

   // Hint readback fields
   localparam int          HINT_TAG_LSB  = 0;
   localparam int          HINT_PH_LSB   = 8;
   localparam int          HINT_PRES     = 10;
   localparam int          HINT_SEQ_LSB  = 12;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // Request sideband, bit 59 down to bit 0
   typedef struct packed {
      logic [31:0] parity;
      logic [3:0]  seq;
      logic [7:0]  steering_value;
      logic        tph_indirect;
      logic [1:0]  tph_type;
      logic        tph_present;
      logic        abort;
      logic [10:0] lower;
   } prs_sideband_t;

   // Hint fields passed to the link
   typedef struct packed {
      logic        present;
      logic [1:0]  ph;
      logic [7:0]  tag;
   } prs_hint_t;

   // AXI4-Lite master to slave
   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } prs_axil_req_t;

   // AXI4-Lite slave to master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } prs_axil_rsp_t;

   // Packet position
   typedef enum logic [0:0] {
      ST_FIRST = 1'b0,
      ST_BODY  = 1'b1
   } prs_pkt_st_t;

endpackage : prs_pkg

// >>> design/prs_parity_chk.sv
// Per-byte odd parity check of the request payload
module prs_parity_chk
   import prs_pkg::*;
#(
   parameter int DATA_W = 256,
   parameter int PAR_W  = 32
) (
   // Beat under test
   input  wire logic [DATA_W-1:0] data_i,
   input  wire logic [PAR_W-1:0]  parity_i,
   // Result
   output logic                   mismatch_o
);

   localparam int LANES = DATA_W / 8;

   logic [LANES-1:0] lane_bad;

   // Only lanes of the configured width are checked
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      assign lane_bad[i] = ~((^data_i[8*i +: 8]) ^ parity_i[i]);
   end

   assign mismatch_o = |lane_bad;

endmodule : prs_parity_chk

// >>> tb/prs_user_model.sv
// User-side request stream model driving beats with byte parity
module prs_user_model
   import prs_pkg::*;
(
   // Clock
   input  wire logic     sys_clk_i,
   // Request stream
   output logic [63:0]   payload_o,
   output prs_sideband_t sideband_o,
   output logic          last_o,
   output logic          valid_o,
   input  wire logic     ready_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      payload_o  = '0;
      sideband_o = '0;
      last_o     = 1'b0;
      valid_o    = 1'b0;
   end

   // Offer one beat, hold everything until taken
   task automatic send(input logic [63:0] d, input prs_sideband_t sb, input logic last,
                       input logic [31:0] flip, input logic par_on);
      sb.parity = flip;
      for (int i = 0; i < 8; i++) begin
         sb.parity[i] = (~^d[8*i+:8]) ^ flip[i];
      end
      if (!par_on) begin
         sb.parity = '0;
      end
      payload_o  <= d;
      sideband_o <= sb;
      last_o     <= last;
      valid_o    <= 1'b1;
      do @(posedge sys_clk_i); while (ready_i !== 1'b1);
   endtask : send

   // Release the stream; lines show changed values
   task automatic idle();
      prs_sideband_t s;
      s = ~sideband_o;
      s.abort = 1'b0;
      valid_o    <= 1'b0;
      last_o     <= 1'b0;
      payload_o  <= ~payload_o;
      sideband_o <= s;
   endtask : idle
endmodule : prs_user_model

// >>> tb/prs_top_tb.sv
// Self-checking bench for the request sideband upper block
module prs_top_tb
   import prs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          sys_clk_i, resetn_i, link_ready_i, last, valid, ready;
   logic          l_last, l_nul, l_valid, pv, aer, ie, irq;
   prs_axil_req_t req;
   prs_axil_rsp_t rsp;
   prs_sideband_t sb;
   prs_hint_t     hint, hint_seen;
   logic [63:0]   pay, l_data;
   logic [3:0]    pnum, pnum_seen;
   logic [7:0]    stt_m [4];
   logic [1:0]    nul_q [$];
   logic [63:0]   dat_q [$];
   int            fail_count, n_tests, cyc, pv_cnt, pv_exp, aer_cnt, ie_cnt;

   prs_top #(.DATA_W(64), .STT_DEPTH(4)) u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .axil_req_i(req), .axil_rsp_o(rsp), .request_stream_payload_i(pay),
      .request_sideband_i(sb), .request_stream_last_i(last), .request_stream_valid_i(valid),
      .request_stream_ready_o(ready), .link_data_o(l_data), .link_last_o(l_last),
      .link_nullify_o(l_nul), .link_valid_o(l_valid), .link_ready_i(link_ready_i),
      .link_hint_o(hint), .progress_number_out_o(pnum), .progress_number_out_valid_o(pv),
      .aer_abort_report_o(aer), .internal_error_report_o(ie), .irq_o(irq));

   prs_user_model u_user (.sys_clk_i(sys_clk_i), .payload_o(pay), .sideband_o(sb),
      .last_o(last), .valid_o(valid), .ready_i(ready));

   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // Link stalls one cycle in four; hang limit
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      link_ready_i <= (cyc % 4) != 3;
      if (cyc == 6000) begin
         fail_count++;
         test_done();
      end
   end

   // Link side and report monitor
   always @(posedge sys_clk_i) begin
      if (l_valid === 1'b1 && link_ready_i) begin
         nul_q.push_back({l_nul, l_last});
         dat_q.push_back(l_data);
         hint_seen = hint;
      end
      if (pv === 1'b1) begin
         pv_cnt++;
         pnum_seen = pnum;
      end
      aer_cnt += int'(aer === 1'b1);
      ie_cnt  += int'(ie === 1'b1);
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic test_done();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w  = 1'b0;
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge sys_clk_i);
         if (rsp.awready && !aw) begin aw = 1'b1; req.awvalid <= 1'b0; end
         if (rsp.wready && !w) begin w = 1'b1; req.wvalid <= 1'b0; end
      end
      do @(posedge sys_clk_i); while (rsp.bvalid !== 1'b1);
      chk("bresp", {30'h0, rsp.bresp}, {30'h0, RESP_OKAY});
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      do @(posedge sys_clk_i); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge sys_clk_i); while (rsp.rvalid !== 1'b1);
      chk("rdata", rsp.rdata, ex);
      chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
   endtask : axr

   function automatic prs_sideband_t mk(logic p, logic [1:0] t, logic ind, logic [7:0] st,
                                        logic [3:0] sq);
      prs_sideband_t s;
      s = '0;
      s.tph_present = p;
      s.tph_type = t;
      s.tph_indirect = ind;
      s.steering_value = st;
      s.seq = sq;
      return s;
   endfunction : mk

   // Packet of nb beats; abort on beat ab, parity flip on beat pb, nullify from beat en
   task automatic pkt(input int nb, input prs_sideband_t s, input int ab, input int pb,
                      input logic [31:0] fl, input logic pon, input int en);
      prs_sideband_t b2;
      prs_hint_t eh;
      logic [63:0] dw;
      for (int b = 0; b < nb; b++) begin
         b2 = s;
         b2.abort = (b == ab);
         if (b > 0) begin
            b2.steering_value = ~s.steering_value;
            b2.tph_type = ~s.tph_type;
            b2.tph_indirect = ~s.tph_indirect;
            b2.seq = ~s.seq;
         end
         u_user.send({32'h0123_4567 + 32'(b), 32'h89AB_CDEF}, b2, b == nb - 1,
                     (b == pb) ? fl : 32'h0000_0000, pon);
      end
      u_user.idle();
      for (int k = 0; k < 200 && nul_q.size() < nb; k++) @(posedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
      chk("beats", nul_q.size(), nb);
      for (int b = 0; b < nb; b++) begin
         chk("nullify", {30'h0, nul_q.pop_front()}, {30'h0, b >= en, b == nb - 1});
         dw = dat_q.pop_front();
         chk("data high", dw[63:32], 32'h0123_4567 + 32'(b));
         chk("data low", dw[31:0], 32'h89AB_CDEF);
      end
      eh = s.tph_present ? {1'b1, s.tph_type,
           s.tph_indirect ? stt_m[s.steering_value[1:0]] : s.steering_value} : '0;
      chk("hint", {21'h0, hint_seen}, {21'h0, eh});
      pv_exp++;
      chk("progress pulses", pv_cnt, pv_exp);
      chk("progress number", {28'h0, pnum_seen}, {28'h0, s.seq});
   endtask : pkt

   initial begin
      resetn_i = 1'b0;
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      stt_m = '{default: STT_RST};
      repeat (12) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      axr(OFF_CTRL, CTRL_RST, RESP_OKAY);
      axr(OFF_MASK, MASK_RST, RESP_OKAY);
      axr(OFF_STATUS, 32'h0000_0000, RESP_OKAY);
      axr(8'h40, 32'h0000_0000, RESP_SLVERR);
      axw(OFF_STT_BASE + 8'h04, 32'h0000_00A5);
      stt_m[1] = 8'hA5;
      axr(OFF_STT_BASE + 8'h04, 32'h0000_00A5, RESP_OKAY);
      pkt(1, mk(1'b1, 2'h2, 1'b1, 8'h05, 4'h7), -1, -1, 0, 1'b1, 9);
      axr(OFF_HINT, 32'h0000_76A5, RESP_OKAY);
      pkt(3, mk(1'b1, 2'h1, 1'b0, 8'h3C, 4'h9), -1, -1, 0, 1'b1, 9);
      pkt(2, mk(1'b0, 2'h3, 1'b1, 8'hFF, 4'h0), -1, -1, 0, 1'b1, 9);
      pkt(3, mk(1'b0, 2'h0, 1'b0, 8'h00, 4'h4), 1, -1, 0, 1'b1, 1);
      chk("aer count", aer_cnt, 1);
      axr(OFF_STATUS, 32'h0000_0005, RESP_OKAY);
      axw(OFF_MASK, 32'h0000_0001);
      repeat (2) @(posedge sys_clk_i);
      chk("irq set", {31'h0, irq}, 1);
      axw(OFF_STATUS, 32'h0000_0001);
      repeat (2) @(posedge sys_clk_i);
      chk("irq clear", {31'h0, irq}, 0);
      axr(OFF_STATUS, 32'h0000_0004, RESP_OKAY);
      pkt(2, mk(1'b0, 2'h0, 1'b0, 8'h00, 4'hB), -1, 0, 32'h0000_0008, 1'b1, 0);
      chk("internal error count", ie_cnt, 1);
      axr(OFF_STATUS, 32'h0000_0006, RESP_OKAY);
      pkt(2, mk(1'b0, 2'h0, 1'b0, 8'h00, 4'hC), -1, 1, 32'h0000_0200, 1'b1, 9);
      axw(OFF_CTRL, 32'h0000_0000);
      pkt(1, mk(1'b0, 2'h0, 1'b0, 8'h00, 4'h1), -1, -1, 0, 1'b0, 9);
      pkt(1, mk(1'b0, 2'h0, 1'b0, 8'h00, 4'h2), 0, -1, 0, 1'b0, 0);
      chk("aer count", aer_cnt, 1);
      chk("internal error count", ie_cnt, 1);
      test_done();
   end
endmodule : prs_top_tb
